// >>> dsb_cfg.svh
`ifndef DSB_CFG_SVH
`define DSB_CFG_SVH

// extended mode register field positions
`define DSB_EMR_WIDTH 16
`define DSB_EMR_COMPLEMENT_DISABLE_BIT 10
`define DSB_EMR_REDUNDANT_ENABLE_BIT 11

// reset values of the captured mode bits
`define DSB_COMPLEMENT_DISABLE_RESET 1'b0
`define DSB_REDUNDANT_ENABLE_RESET 1'b0

// data bus layout
`define DSB_DQ_WIDTH 16
`define DSB_BYTE_LANES 2
`define DSB_NIBBLE_LO_MASK 16'h000F
`define DSB_BYTE_LO_MASK 16'h00FF
`define DSB_ALL_MASK 16'hFFFF

// synchroniser depth for pins from the link
`define DSB_SYNC_STAGES 2

`endif

// >>> dsb_pkg.sv
package dsb_pkg;

    typedef enum logic [1:0] {
        DSB_WIDTH_X4 = 2'b00,
        DSB_WIDTH_X8 = 2'b01,
        DSB_WIDTH_X16 = 2'b10
    } dsb_width_type;

endpackage

// >>> dsb_strobe_balls.sv
`timescale 1ns/100ps
`include "dsb_cfg.svh"

// Function
// - strobe outputs on reads, inputs on writes
// - read strobe edges move with data
// - complement strobe only in differential mode
// - x16: separate low and high byte strobes
// - x8: redundant strobe enabled by mode register load
// - redundant strobe driven on reads only
// - redundant strobe off: ball is write mask
// - redundant complement needs both modes enabled
// - x16: bit ten zero enables byte complements
// - x8: bit ten zero enables both complements
// - upper nibble balls: data on x8, none x4
// - masked write bytes discarded, both edges
module dsb_strobe_balls
    import dsb_pkg::*;
#(
    parameter int DQ_WIDTH = `DSB_DQ_WIDTH,
    parameter int LANES = `DSB_BYTE_LANES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire dsb_width_type width_sel,
    input wire logic emr_load,
    input wire logic [`DSB_EMR_WIDTH-1:0] emr_value,
    input wire logic read_active,
    input wire logic read_beat,
    input wire logic [DQ_WIDTH-1:0] read_data,
    input wire logic write_active,
    output logic write_valid,
    output logic [DQ_WIDTH-1:0] write_data,
    output logic [LANES-1:0] write_keep,
    input wire logic [DQ_WIDTH-1:0] dq_in,
    output logic [DQ_WIDTH-1:0] dq_out,
    output logic [DQ_WIDTH-1:0] dq_oe,
    input wire logic [LANES-1:0] strobe_in,
    output logic [LANES-1:0] strobe_out,
    output logic [LANES-1:0] strobe_oe,
    input wire logic [LANES-1:0] strobe_n_in,
    output logic [LANES-1:0] strobe_n_out,
    output logic [LANES-1:0] strobe_n_oe,
    input wire logic [LANES-1:0] write_mask_in,
    input wire logic redundant_read_strobe_in,
    output logic redundant_read_strobe_out,
    output logic redundant_read_strobe_oe,
    output logic redundant_read_strobe_n_out,
    output logic redundant_read_strobe_n_oe,
    output logic differential_mode,
    output logic redundant_enabled
);

    logic strobe_complement_disable;
    logic redundant_enable;
    logic read_drive;
    logic read_level;
    logic [DQ_WIDTH-1:0] read_word;

    // mode bits captured on a mode register load
    // reset leaves differential strobes on and the redundant strobe off;
    // a load replaces both bits at once
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            strobe_complement_disable <= `DSB_COMPLEMENT_DISABLE_RESET;
            redundant_enable <= `DSB_REDUNDANT_ENABLE_RESET;
        end else if (emr_load) begin
            strobe_complement_disable <= emr_value[`DSB_EMR_COMPLEMENT_DISABLE_BIT];
            redundant_enable <= emr_value[`DSB_EMR_REDUNDANT_ENABLE_BIT];
        end
    end

    wire is_x8 = (width_sel == DSB_WIDTH_X8);
    wire is_x16 = (width_sel == DSB_WIDTH_X16);
    wire diff_on = !strobe_complement_disable;
    wire redundant_read_strobe_n_on = is_x8 && redundant_enable;

    // balls in use for the configured width
    wire [DQ_WIDTH-1:0] width_mask = is_x16 ? `DSB_ALL_MASK :
        (is_x8 ? `DSB_BYTE_LO_MASK : `DSB_NIBBLE_LO_MASK);
    wire [LANES-1:0] lane_used = {is_x16, 1'b1};

    assign differential_mode = diff_on;
    assign redundant_enabled = redundant_read_strobe_n_on;

    // read side: strobe toggles in the same cycle the data changes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            read_drive <= 1'b0;
            read_level <= 1'b0;
            read_word <= '0;
        end else begin
            read_drive <= read_active;
            if (!read_active) begin
                read_level <= 1'b0;
            end else if (read_beat) begin
                read_level <= !read_level;
                read_word <= read_data;
            end
        end
    end

    // pins are released one cycle after the read window closes
    assign dq_out = read_word;
    assign dq_oe = read_drive ? width_mask : '0;
    assign strobe_out = {LANES{read_level}};
    assign strobe_oe = read_drive ? lane_used : '0;
    assign strobe_n_out = {LANES{!read_level}};
    assign strobe_n_oe = (read_drive && diff_on) ? lane_used : '0;
    assign redundant_read_strobe_out = read_level;
    assign redundant_read_strobe_oe = read_drive && redundant_read_strobe_n_on;
    assign redundant_read_strobe_n_out = !read_level;
    assign redundant_read_strobe_n_oe = read_drive && redundant_read_strobe_n_on && diff_on;

    // write side: every link pin passes two flip-flops first
    logic [DQ_WIDTH-1:0] dq_s1;
    logic [DQ_WIDTH-1:0] dq_s2;
    logic [LANES-1:0] dqs_s1;
    logic [LANES-1:0] dqs_s2;
    logic [LANES-1:0] dqs_s3;
    logic [LANES-1:0] dqsn_s1;
    logic [LANES-1:0] dqsn_s2;
    logic [LANES-1:0] mask_s1;
    logic [LANES-1:0] mask_s2;
    logic redundant_read_strobe_n_s1;
    logic redundant_read_strobe_n_s2;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
            dqs_s1 <= '0;
            dqs_s2 <= '0;
            dqsn_s1 <= '1;
            dqsn_s2 <= '1;
            mask_s1 <= '0;
            mask_s2 <= '0;
            redundant_read_strobe_n_s1 <= 1'b0;
            redundant_read_strobe_n_s2 <= 1'b0;
        end else begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            dqs_s1 <= strobe_in;
            dqs_s2 <= dqs_s1;
            dqsn_s1 <= strobe_n_in;
            dqsn_s2 <= dqsn_s1;
            mask_s1 <= write_mask_in;
            mask_s2 <= mask_s1;
            redundant_read_strobe_n_s1 <= redundant_read_strobe_in;
            redundant_read_strobe_n_s2 <= redundant_read_strobe_n_s1;
        end
    end

    // captures wait until the synchronisers hold real pin levels: a strobe
    // left high across reset would otherwise look like a fresh edge
    localparam int SETTLE = `DSB_SYNC_STAGES + 1;
    logic [1:0] settle_count;
    wire sync_ready = (settle_count == 2'(SETTLE));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            settle_count <= 2'h0;
        end else if (!sync_ready) begin
            settle_count <= settle_count + 2'h1;
        end
    end

    // no capture while the device drives the strobes or is about to turn
    // the bus round, so a read never leaks into the write path
    wire capture_open = write_active && sync_ready && !read_active && !read_drive;

    // shared ball is the low mask when the redundant strobe is off
    wire low_mask = is_x8 ? (!redundant_enable && redundant_read_strobe_n_s2) : mask_s2[0];
    wire [LANES-1:0] lane_mask = {is_x16 && mask_s2[1], low_mask};

    // differential receive: true high and complement low
    wire [LANES-1:0] dqs_level = diff_on ? (dqs_s2 & ~dqsn_s2) : dqs_s2;
    wire [LANES-1:0] lane_edge;
    logic [LANES-1:0] lane_keep;
    logic [DQ_WIDTH-1:0] lane_data;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dqs_s3 <= '0;
        end else begin
            dqs_s3 <= dqs_level;
        end
    end

    // each used lane takes one byte per strobe level change
    genvar b;
    generate
        for (b = 0; b < LANES; b = b + 1) begin : g_lane
            // both edges capture while the device is not driving
            assign lane_edge[b] = lane_used[b] && capture_open
                && (dqs_level[b] != dqs_s3[b]);
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    lane_keep[b] <= 1'b0;
                    lane_data[8*b +: 8] <= 8'h00;
                end else if (lane_edge[b]) begin
                    lane_keep[b] <= !lane_mask[b];
                    lane_data[8*b +: 8] <= dq_s2[8*b +: 8] & width_mask[8*b +: 8];
                end
            end
        end
    endgenerate

    // one pulse per beat; the lanes of one beat land in the same cycle
    logic wr_pulse;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_pulse <= 1'b0;
        end else begin
            wr_pulse <= |lane_edge;
        end
    end

    assign write_valid = wr_pulse;
    assign write_data = lane_data;
    assign write_keep = wr_pulse ? (lane_keep & lane_used) : '0;

endmodule

// >>> dsb_strobe_balls_chk.sv
`timescale 1ns/100ps
module dsb_strobe_balls_chk
    import dsb_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic emr_load,
    input wire logic read_active,
    input wire logic read_beat,
    input wire logic write_valid,
    input wire logic differential_mode,
    input wire logic redundant_enabled,
    input wire logic redundant_read_strobe_oe,
    input wire logic redundant_read_strobe_n_oe,
    input wire logic [15:0] emr_value,
    input wire logic [15:0] dq_oe,
    input wire logic [1:0] strobe_out,
    input wire logic [1:0] strobe_oe,
    input wire logic [1:0] strobe_n_out,
    input wire logic [1:0] strobe_n_oe,
    input wire logic [1:0] write_keep,
    input wire dsb_width_type width_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_diff; emr_load |=> differential_mode == !$past(emr_value[10]); endproperty
    a_diff: assert property (p_diff) else $error("mode");
    property p_red; emr_load |=> redundant_enabled == ($past(emr_value[11]) && width_sel == DSB_WIDTH_X8); endproperty
    a_red: assert property (p_red) else $error("redundant");
    property p_open; $rose(read_active) |=> strobe_oe[0]; endproperty
    a_open: assert property (p_open) else $error("open");
    property p_close; $fell(read_active) |=> !strobe_oe[0] && !redundant_read_strobe_oe; endproperty
    a_close: assert property (p_close) else $error("close");
    property p_edge; read_active && read_beat |=> strobe_out[0] != $past(strobe_out[0]); endproperty
    a_edge: assert property (p_edge) else $error("edge");
    property p_comp; strobe_n_oe[0] |-> differential_mode && strobe_n_out[0] != strobe_out[0]; endproperty
    a_comp: assert property (p_comp) else $error("complement");
    property p_rds; redundant_read_strobe_oe |-> redundant_enabled && strobe_oe[0]; endproperty
    a_rds: assert property (p_rds) else $error("shared ball");
    property p_keep; !write_valid |-> write_keep == 2'h0; endproperty
    a_keep: assert property (p_keep) else $error("keep");
    property p_rdn; redundant_read_strobe_n_oe |-> redundant_enabled && differential_mode; endproperty
    a_rdn: assert property (p_rdn) else $error("redundant complement");
    property p_lane; (strobe_oe[1] || dq_oe[15:8] != 8'h00) |-> width_sel == DSB_WIDTH_X16; endproperty
    a_lane: assert property (p_lane) else $error("high byte lane");
    property p_nib; dq_oe[7:4] != 4'h0 |-> width_sel != DSB_WIDTH_X4; endproperty
    a_nib: assert property (p_nib) else $error("upper nibble");
    c_read: cover property (read_beat && strobe_oe[0]);
    c_write: cover property (write_valid && write_keep == 2'h0);
    c_red: cover property (redundant_read_strobe_oe);
    c_wide: cover property (strobe_oe == 2'h3);
endmodule
bind dsb_strobe_balls dsb_strobe_balls_chk i_chk (.*);

// >>> dsb_ctrl_model.sv
`timescale 1ns/100ps
module dsb_ctrl_model (
    output logic [15:0] dq_in,
    output logic [1:0] strobe_in,
    output logic [1:0] strobe_n_in,
    output logic [1:0] write_mask_in,
    output logic redundant_read_strobe_in
);
    // idle: strobes low, complements high, no mask
    initial {dq_in, strobe_in, strobe_n_in, write_mask_in, redundant_read_strobe_in} = 23'h000018;
    // one beat of a 400 ns link clock, strobe edge in the middle of the bit
    task automatic beat(input logic [15:0] d, input logic [1:0] m);
        dq_in = d;
        write_mask_in = m;
        redundant_read_strobe_in = m[0];
        #100 strobe_in = ~strobe_in;
        strobe_n_in = ~strobe_in;
        #100 dq_in = ~d;
        write_mask_in = ~m;
    endtask
endmodule

// >>> dsb_strobe_balls_test.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH %0t got %h want %h", $time, (a), (e)); end end
module dsb_strobe_balls_test
    import dsb_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, emr_load = 1'b0, read_active = 1'b0, read_beat = 1'b0, write_active = 1'b0;
    dsb_width_type width_sel = DSB_WIDTH_X8;
    logic [15:0] emr_value = 16'h0000, read_data = 16'h0000, write_data, dq_in, dq_out, dq_oe;
    logic [1:0] write_keep, strobe_in, strobe_out, strobe_oe, strobe_n_in, strobe_n_out, strobe_n_oe, write_mask_in;
    logic write_valid, redundant_read_strobe_in, redundant_read_strobe_out, redundant_read_strobe_oe;
    logic redundant_read_strobe_n_out, redundant_read_strobe_n_oe, differential_mode, redundant_enabled;
    int num_errors = 0, n_tests = 0, cycles = 0;
    dsb_strobe_balls i_dut (.*);
    dsb_ctrl_model i_ctrl (.*);
    always #25 clk = ~clk;
    task automatic finish_test();
        $display("errors %0d of %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic rst(input dsb_width_type w);
        width_sel <= w;
        reset_n <= 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
    endtask
    task automatic load(input logic [15:0] v);
        @(posedge clk);
        emr_load <= 1'b1;
        emr_value <= v;
        @(posedge clk);
        emr_load <= 1'b0;
        #1;
        `CHK(differential_mode, ~v[10])
        `CHK(redundant_enabled, v[11] & (width_sel == DSB_WIDTH_X8))
    endtask
    task automatic t_read(input logic [15:0] e_oe, input logic [1:0] e_lanes, input logic e_rd, input logic e_n);
        @(posedge clk);
        read_active <= 1'b1;
        @(posedge clk);
        read_beat <= 1'b1;
        read_data <= 16'h5AC3;
        @(posedge clk);
        read_data <= 16'hA53C;
        #1;
        `CHK({dq_out & e_oe, strobe_out & e_lanes, strobe_n_out & e_lanes}, {16'h5AC3 & e_oe, e_lanes, 2'h0})
        `CHK({redundant_read_strobe_out, redundant_read_strobe_n_out} & {2{e_rd}}, {e_rd, 1'b0})
        `CHK({dq_oe, strobe_oe, redundant_read_strobe_oe}, {e_oe, e_lanes, e_rd})
        `CHK({strobe_n_oe, redundant_read_strobe_n_oe}, {e_n ? e_lanes : 2'h0, e_n & e_rd})
        @(posedge clk);
        read_beat <= 1'b0;
        read_active <= 1'b0;
        #1;
        `CHK({dq_out & e_oe, strobe_out & e_lanes, strobe_n_out & e_lanes}, {16'hA53C & e_oe, 2'h0, e_lanes})
        @(posedge clk);
        #1;
        `CHK({dq_oe, strobe_oe, strobe_n_oe, redundant_read_strobe_oe}, 21'h000000)
    endtask
    task automatic t_write(input logic [15:0] d, input logic [1:0] m, input logic [15:0] ed, input logic [1:0] ek);
        int i;
        @(posedge clk);
        write_active <= 1'b1;
        fork
            #17 i_ctrl.beat(d, m);
            begin
                for (i = 0; i < 20 && write_valid !== 1'b1; i++) begin
                    @(posedge clk);
                    #1;
                end
                `CHK(write_valid, 1'b1)
                `CHK(write_data, ed)
                `CHK(write_keep, ek)
            end
        join
        @(posedge clk);
        write_active <= 1'b0;
    endtask
    initial begin
        rst(DSB_WIDTH_X8);
        load(16'h0400);
        load(16'h0800);
        t_read(16'h00FF, 2'h1, 1'b1, 1'b1);
        load(16'h0C00);
        t_read(16'h00FF, 2'h1, 1'b1, 1'b0);
        t_write(16'hA55A, 2'h1, 16'h005A, 2'h1);
        load(16'h0000);
        t_write(16'hA55A, 2'h1, 16'h005A, 2'h0);
        rst(DSB_WIDTH_X16);
        t_read(16'hFFFF, 2'h3, 1'b0, 1'b1);
        t_write(16'hA55A, 2'h2, 16'hA55A, 2'h1);
        rst(DSB_WIDTH_X4);
        t_write(16'hA55A, 2'h0, 16'h000A, 2'h1);
        finish_test();
    end
endmodule
